// ===== tb/fps_plant.sv
/*
 * Behavioural power stage beside the sequencer: switch, transformer, sense divider, supply.
 * Assumes the bench sets the load level, overvoltage, overheating and ramp length.
 */
`timescale 1ns/1ps
module fps_plant
	import fps_pkg::*;
(
	input wire logic clk,
	input wire logic gate_drive,
	input wire logic [2:0] ctrl_lvl,
	input wire logic ovp_sense,
	input wire logic ovp_supply,
	input wire logic hot,
	input wire logic [9:0] ton,
	output fps_cmp_t cmp
);
	int on_n = 0;
	int off_n = 5000;
	int vcc = 0;
	logic up = 1'b1;

	////////////////////////////////////////////////////////////////
	// Aux winding holds the supply while switching, else it sags and recharges
	always @(posedge clk)
	begin
		on_n <= gate_drive ? on_n + 1 : 0;
		off_n <= gate_drive ? 0 : off_n + 1;
		if (off_n < 1200)
		begin
			vcc <= 20;
			up <= 1'b0;
		end
		else if (up)
		begin
			vcc <= vcc + 1;
			up <= vcc < 29;
		end
		else
		begin
			vcc <= vcc - 1;
			up <= vcc < 10;
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		cmp.ctrl_above_400mv = ctrl_lvl[2];
		cmp.ctrl_low_power = ctrl_lvl[1];
		cmp.ctrl_peak_power = ctrl_lvl[0];
		// Turn-on spike, then the ramp reaching the control level
		cmp.sense_above_ctrl = gate_drive && (on_n < 3 || on_n >= int'(ton));
		// Ringing after turn-off, then the reflected output voltage
		cmp.sense_above_ovp = !gate_drive && off_n < 300 && (off_n < 30 ? off_n[0] : ovp_sense);
		cmp.supply_above_ovp = ovp_supply;
		cmp.supply_below_lockout = vcc < 13;
		cmp.supply_at_startup = vcc > 20;
		cmp.temp_over = hot;
	end
endmodule

// ===== tb/fps_sequencer_tb.sv
/*
 * Self-checking bench of the protection sequencer, with the power stage model.
 * Assumes the overload timeout shortened to 200 cycles.
 */
`timescale 1ns/1ps
module fps_sequencer_tb
	import fps_pkg::*;
;
	typedef struct packed
	{
		logic [2:0] lvl;
		fps_mode_t mode;
		logic [1:0] ceil;
		logic comp;
		logic [9:0] per;
	} fps_row_t;

	localparam fps_row_t ROWS [3] = '{
		'{3'h0, MODE_HIGH, CEIL_HIGH, 1'b1, PER_HIGH},
		'{3'h1, MODE_PEAK, CEIL_PEAK, 1'b1, PER_PEAK},
		'{3'h2, MODE_LOW, CEIL_LOW, 1'b0, PER_LOW}};

	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] lvl = 3'h0;
	logic osen = 1'b0;
	logic osup = 1'b0;
	logic hot = 1'b0;
	logic [9:0] ton = 10'h028;
	fps_cmp_t cmp;
	logic gate;
	fps_stat_t st;
	int n_fail = 0;
	int total_checks = 0;
	int n_rise = 0;
	int n_up = 0;
	int n;
	int k;

	always #20 clk = ~clk;
	always @(posedge gate) n_rise++;
	always @(posedge cmp.supply_at_startup) n_up++;

	fps_sequencer #(.OVERLOAD_CYC(200)) DUT (.clk(clk), .nrst(nrst), .cmp_in(cmp), .gate_drive(gate), .status(st));
	fps_plant plant (.clk(clk), .gate_drive(gate), .ctrl_lvl(lvl), .ovp_sense(osen), .ovp_supply(osup),
		.hot(hot), .ton(ton), .cmp(cmp));

	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// Cycles until the next gate rise
	task automatic rise(output int c);
		c = 0;
		while (gate !== 1'b0 && c < 3000)
		begin
			tick(1);
			c++;
		end
		while (gate !== 1'b1 && c < 3000)
		begin
			tick(1);
			c++;
		end
	endtask

	task automatic rises(input int c);
		int d;
		repeat (c) rise(d);
	endtask

	task automatic high_len(output int c);
		c = 0;
		while (gate === 1'b1 && c < 2000)
		begin
			tick(1);
			c++;
		end
	endtask

	task automatic wait_rst(input logic v);
		for (int i = 0; i < 6000 && st.restarting !== v; i++) tick(1);
	endtask

	// Supply removal, then start-up
	task automatic cycle_power();
		nrst = 1'b0;
		tick(4);
		chk(gate === 1'b0 && st.restarting === 1'b1 && st.latched === 1'b0 && st.mode === MODE_HIGH, "reset");
		nrst = 1'b1;
		rise(n);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		tick(1);
		cycle_power();
		foreach (ROWS[i])
		begin
			lvl = ROWS[i].lvl;
			rises(2);
			rise(n);
			chk(st.mode === ROWS[i].mode && st.peak_ceiling === ROWS[i].ceil, "mode");
			chk(st.comp_enable === ROWS[i].comp, "compensation");
			chk(10'(n) === ROWS[i].per, "period");
			high_len(n);
			chk(n > int'(ton) && n < int'(ton) + 10, "on time");
		end
		lvl = 3'h0;
		rises(2);
		ton = 10'h3ff;
		high_len(n);
		chk(n >= 306 && n <= 308, "max duty");
		k = n_rise;
		for (n = 0; n < 4000 && st.restarting !== 1'b1; n++) tick(1);
		chk(n_rise - k === 7 && gate === 1'b0, "max duty restart");
		ton = 10'h028;
		wait_rst(1'b0);
		rise(n);
		lvl = 3'h4;
		tick(150);
		lvl = 3'h0;
		tick(20);
		lvl = 3'h4;
		tick(150);
		chk(st.restarting === 1'b0, "timer cleared");
		tick(80);
		chk(st.restarting === 1'b1 && gate === 1'b0, "overpower");
		lvl = 3'h0;
		k = n_up;
		n = n_rise;
		wait_rst(1'b0);
		chk(n_up - k === 3 && n_rise === n, "three recharges");
		rise(n);
		osen = 1'b1;
		rises(3);
		osen = 1'b0;
		rises(2);
		chk(st.latched === 1'b0, "sense count cleared");
		osen = 1'b1;
		rises(3);
		chk(st.latched === 1'b0, "sense count restarted");
		tick(150);
		chk(st.latched === 1'b1 && gate === 1'b0, "sense overvoltage");
		osen = 1'b0;
		k = n_rise;
		tick(1500);
		chk(st.latched === 1'b1 && n_rise === k, "stays off");
		cycle_power();
		chk(st.latched === 1'b0, "latch cleared");
		osup = 1'b1;
		rises(3);
		osup = 1'b0;
		rises(2);
		osup = 1'b1;
		rises(3);
		chk(st.latched === 1'b0, "supply count cleared");
		tick(400);
		chk(st.latched === 1'b1 && gate === 1'b0, "supply overvoltage");
		osup = 1'b0;
		cycle_power();
		hot = 1'b1;
		tick(20);
		hot = 1'b0;
		k = n_rise;
		tick(2000);
		chk(st.latched === 1'b1 && n_rise === k, "overtemperature");
		cycle_power();
		chk(st.latched === 1'b0 && gate === 1'b1, "restart after removal");
		stop_test();
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule

// ===== verilog/fps_pkg.sv
/*
 * Constants and carrier types of the flyback protection sequencer.
 * Assumes a 25 MHz internal clock; analog comparators arrive as levels.
 */
package fps_pkg;

	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned OVERLOAD_TIMEOUT_MS = 60;
	localparam int unsigned OVERLOAD_TIMEOUT_CYC = (CLK_HZ / 1000) * OVERLOAD_TIMEOUT_MS;
	localparam int unsigned OVP_SAMPLE_NS = 2000;
	localparam int unsigned OVP_SAMPLE_CYC = (OVP_SAMPLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned LEB_NS = 300;
	localparam int unsigned LEB_CYC = (LEB_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned F_HIGH_KHZ = 65;
	localparam int unsigned F_PEAK_KHZ = 80;
	localparam int unsigned F_LOW_KHZ = 25;
	localparam logic [9:0] PER_HIGH = 10'((CLK_HZ / 1000) / F_HIGH_KHZ);
	localparam logic [9:0] PER_PEAK = 10'((CLK_HZ / 1000) / F_PEAK_KHZ);
	localparam logic [9:0] PER_LOW = 10'((CLK_HZ / 1000) / F_LOW_KHZ);
	localparam logic [9:0] TON_MAX_PCT = 10'h050;
	localparam logic [2:0] OVP_LIMIT = 3'h4;
	localparam logic [1:0] OVERLOAD_RESTARTS = 2'h3;
	localparam logic [3:0] MAXDUTY_LIMIT = 4'h8;
	localparam logic [1:0] CEIL_LOW = 2'h1;
	localparam logic [1:0] CEIL_HIGH = 2'h2;
	localparam logic [1:0] CEIL_PEAK = 2'h3;

	typedef enum logic [2:0]
	{
		MODE_LOW = 3'h1,
		MODE_HIGH = 3'h2,
		MODE_PEAK = 3'h4
	} fps_mode_t;

	typedef enum logic [3:0]
	{
		ST_RUN = 4'h1,
		ST_DISCHARGE = 4'h2,
		ST_RECHARGE = 4'h4,
		ST_LATCHED = 4'h8
	} fps_state_t;

	// Comparator levels from the analog front end
	typedef struct packed
	{
		logic ctrl_above_400mv;
		logic ctrl_low_power;
		logic ctrl_peak_power;
		logic sense_above_ctrl;
		logic sense_above_ovp;
		logic supply_above_ovp;
		logic supply_below_lockout;
		logic supply_at_startup;
		logic temp_over;
	} fps_cmp_t;

	// Status toward the gate driver and compensation
	typedef struct packed
	{
		fps_mode_t mode;
		logic [1:0] peak_ceiling;
		logic comp_enable;
		logic latched;
		logic restarting;
	} fps_stat_t;

endpackage

// ===== verilog/fps_sequencer.sv
/*
 * Digital protection and mode sequencer of a flyback controller.
 * Assumes comparator levels asynchronous to clk; supply power-up drives nrst.
 */
`timescale 1ns/1ps
module fps_sequencer
	import fps_pkg::*;
#(
	parameter int unsigned OVERLOAD_CYC = OVERLOAD_TIMEOUT_CYC
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire fps_cmp_t cmp_in,
	output logic gate_drive,
	output fps_stat_t status
);

	////////////////////////////////////////////////////////////////////////
	// Three-stage input synchronisers
	localparam int unsigned NCMP = $bits(fps_cmp_t);
	logic [NCMP-1:0] s1_q, s2_q, s3_q;
	logic [NCMP-1:0] clean_q, clean_d;
	fps_cmp_t cmp;

	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++)
		begin : g_sync
			always_comb
			begin
				clean_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : clean_q[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			clean_q <= '0;
		end
		else
		begin
			s1_q <= cmp_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign cmp = fps_cmp_t'(clean_q);

	////////////////////////////////////////////////////////////////////////
	// Oscillator, stroke and protection state
	fps_state_t st_q, st_d;
	fps_mode_t mode_q, mode_d;
	logic [9:0] cyc_q, cyc_d;
	logic gate_q, gate_d;
	logic [9:0] since_off_q, since_off_d;
	logic sampled_q, sampled_d;
	logic [2:0] sovp_q, sovp_d;
	logic [2:0] vovp_q, vovp_d;
	logic [3:0] maxd_q, maxd_d;
	logic [31:0] ovld_q, ovld_d;
	logic [1:0] rst_left_q, rst_left_d;

	logic [9:0] period;
	logic [9:0] ton_max;
	logic cycle_start;
	logic blanked;
	logic fault_latch;

	function automatic logic [9:0] period_of(input fps_mode_t m);
		case (m)
			MODE_LOW: period_of = PER_LOW;
			MODE_PEAK: period_of = PER_PEAK;
			default: period_of = PER_HIGH;
		endcase
	endfunction

	always_comb
	begin
		period = period_of(mode_q);
		ton_max = 10'((32'(period) * 32'(TON_MAX_PCT)) / 32'd100);
		cycle_start = (cyc_q == 10'h000);
		blanked = (cyc_q < 10'(LEB_CYC));
		fault_latch = (sovp_q == OVP_LIMIT) || (vovp_q == OVP_LIMIT) || cmp.temp_over;

		// Mode select; period changes only at cycle boundary
		mode_d = mode_q;
		if (cycle_start)
		begin
			if (cmp.ctrl_low_power)
				mode_d = MODE_LOW;
			else if (cmp.ctrl_peak_power)
				mode_d = MODE_PEAK;
			else
				mode_d = MODE_HIGH;
		end

		cyc_d = (cyc_q + 10'h001 >= period) ? 10'h000 : cyc_q + 10'h001;
		gate_d = gate_q;
		since_off_d = since_off_q;
		sampled_d = sampled_q;
		sovp_d = sovp_q;
		vovp_d = vovp_q;
		maxd_d = maxd_q;
		ovld_d = ovld_q;
		st_d = st_q;
		rst_left_d = rst_left_q;

		case (st_q)
			ST_RUN:
			begin
				if (cycle_start)
				begin
					gate_d = 1'b1;
					sampled_d = 1'b0;
					if (cmp.supply_above_ovp)
						vovp_d = vovp_q + 3'h1;
					else
						vovp_d = 3'h0;
				end
				else if (gate_q && !blanked && cmp.sense_above_ctrl)
				begin
					gate_d = 1'b0;
					since_off_d = 10'h000;
					maxd_d = 4'h0;
				end
				else if (gate_q && cyc_q >= ton_max)
				begin
					gate_d = 1'b0;
					since_off_d = 10'h000;
					maxd_d = maxd_q + 4'h1;
				end
				if (!gate_q && !sampled_q)
				begin
					since_off_d = since_off_q + 10'h001;
					if (since_off_q == 10'(OVP_SAMPLE_CYC - 1))
					begin
						sampled_d = 1'b1;
						sovp_d = cmp.sense_above_ovp ? sovp_q + 3'h1 : 3'h0;
					end
				end
				if (cmp.ctrl_above_400mv)
					ovld_d = ovld_q + 32'h1;
				else
					ovld_d = 32'h0;
				if (fault_latch)
				begin
					st_d = ST_LATCHED;
					gate_d = 1'b0;
				end
				else if (ovld_q >= OVERLOAD_CYC)
				begin
					st_d = ST_DISCHARGE;
					rst_left_d = OVERLOAD_RESTARTS;
					gate_d = 1'b0;
				end
				else if (maxd_q == MAXDUTY_LIMIT || cmp.supply_below_lockout)
				begin
					st_d = ST_DISCHARGE;
					rst_left_d = 2'h1;
					gate_d = 1'b0;
				end
			end
			ST_DISCHARGE:
			begin
				gate_d = 1'b0;
				ovld_d = 32'h0;
				maxd_d = 4'h0;
				sovp_d = 3'h0;
				vovp_d = 3'h0;
				if (cmp.supply_below_lockout)
					st_d = ST_RECHARGE;
			end
			ST_RECHARGE:
			begin
				gate_d = 1'b0;
				if (cmp.supply_at_startup)
				begin
					rst_left_d = rst_left_q - 2'h1;
					st_d = (rst_left_q == 2'h1) ? ST_RUN : ST_DISCHARGE;
				end
			end
			default:
			begin
				gate_d = 1'b0;
				st_d = ST_LATCHED;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= ST_RECHARGE;
			mode_q <= MODE_HIGH;
			cyc_q <= '0;
			gate_q <= 1'b0;
			since_off_q <= '0;
			sampled_q <= 1'b1;
			sovp_q <= '0;
			vovp_q <= '0;
			maxd_q <= '0;
			ovld_q <= '0;
			rst_left_q <= 2'h1;
		end
		else
		begin
			st_q <= st_d;
			mode_q <= mode_d;
			cyc_q <= cyc_d;
			gate_q <= gate_d;
			since_off_q <= since_off_d;
			sampled_q <= sampled_d;
			sovp_q <= sovp_d;
			vovp_q <= vovp_d;
			maxd_q <= maxd_d;
			ovld_q <= ovld_d;
			rst_left_q <= rst_left_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign gate_drive = gate_q;
	assign status.mode = mode_q;
	assign status.peak_ceiling = (mode_q == MODE_LOW) ? CEIL_LOW : (mode_q == MODE_PEAK) ? CEIL_PEAK : CEIL_HIGH;
	assign status.comp_enable = (mode_q != MODE_LOW);
	assign status.latched = (st_q == ST_LATCHED);
	assign status.restarting = (st_q == ST_DISCHARGE) || (st_q == ST_RECHARGE);

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_latch_holds;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_LATCHED |=> st_q == ST_LATCHED && !gate_q;
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("latch released");

	property p_temp_latch;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && cmp.temp_over |=> st_q == ST_LATCHED;
	endproperty
	a_temp_latch: assert property (p_temp_latch) else $error("overtemperature not latched");

	property p_sense_ovp;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && sovp_q == OVP_LIMIT |=> st_q == ST_LATCHED;
	endproperty
	a_sense_ovp: assert property (p_sense_ovp) else $error("sense overvoltage not latched");

	property p_supply_ovp_clear;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && cycle_start && !cmp.supply_above_ovp |=> vovp_q == 3'h0;
	endproperty
	a_supply_ovp_clear: assert property (p_supply_ovp_clear) else $error("supply counter not cleared");

	property p_overload_trip;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && ovld_q >= OVERLOAD_CYC && !fault_latch
			|=> st_q == ST_DISCHARGE && rst_left_q == OVERLOAD_RESTARTS;
	endproperty
	a_overload_trip: assert property (p_overload_trip) else $error("overpower not tripped");

	property p_overload_clear;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && !cmp.ctrl_above_400mv |=> ovld_q == 32'h0;
	endproperty
	a_overload_clear: assert property (p_overload_clear) else $error("overload timer not cleared");

	property p_blank;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && gate_q && blanked && !cycle_start && !fault_latch && ovld_q < OVERLOAD_CYC
			&& maxd_q != MAXDUTY_LIMIT && !cmp.supply_below_lockout && cyc_q < ton_max |=> gate_q;
	endproperty
	a_blank: assert property (p_blank) else $error("stroke ended while blanked");

	property p_supply_ovp;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && vovp_q == OVP_LIMIT |=> st_q == ST_LATCHED && !gate_q;
	endproperty
	a_supply_ovp: assert property (p_supply_ovp) else $error("supply overvoltage not latched");

	property p_maxduty;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RUN && maxd_q == MAXDUTY_LIMIT && !fault_latch |=> st_q == ST_DISCHARGE && !gate_q;
	endproperty
	a_maxduty: assert property (p_maxduty) else $error("maximum duty run not restarted");

	property p_restart_again;
		@(posedge clk) disable iff (!nrst)
		st_q == ST_RECHARGE && cmp.supply_at_startup && rst_left_q != 2'h1 |=> st_q == ST_DISCHARGE;
	endproperty
	a_restart_again: assert property (p_restart_again) else $error("restart cycle skipped");

	property p_lowpower_comp;
		@(posedge clk) disable iff (!nrst)
		mode_q == MODE_LOW |-> !status.comp_enable && status.peak_ceiling == CEIL_LOW;
	endproperty
	a_lowpower_comp: assert property (p_lowpower_comp) else $error("low power outputs wrong");

	c_latched: cover property (@(posedge clk) disable iff (!nrst) st_q == ST_RUN ##1 st_q == ST_LATCHED);
	c_overload: cover property (@(posedge clk) disable iff (!nrst) rst_left_q == 2'h3 && st_q == ST_RECHARGE);
	c_peak: cover property (@(posedge clk) disable iff (!nrst) mode_q == MODE_PEAK && gate_q);
	c_resume: cover property (@(posedge clk) disable iff (!nrst) st_q == ST_RECHARGE ##1 st_q == ST_RUN);

endmodule
